// *** design/eawt_consts.svh ***
// Register offsets, field positions, reset values and widths of the area wait timing block
`ifndef EAWT_CONSTS_SVH
`define EAWT_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define EAWT_OFS_WAIT 4'h0
`define EAWT_OFS_CTRL 4'h4
`define EAWT_OFS_STAT 4'h8

// ----------------------------------------
// Wait control field positions
// ----------------------------------------
`define EAWT_BAS_BIT 21
`define EAWT_MPX_BIT 20
`define EAWT_WW_MSB 18
`define EAWT_WW_LSB 16
`define EAWT_SW_MSB 12
`define EAWT_SW_LSB 11
`define EAWT_WR_MSB 10
`define EAWT_WR_LSB 7
`define EAWT_WM_BIT 6
`define EAWT_HW_MSB 1
`define EAWT_HW_LSB 0

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define EAWT_WAIT_RST 32'h0000_0500
`define EAWT_WAIT_MASK 32'h0037_1FC3
`define EAWT_CTRL_RST 2'h0

// ----------------------------------------
// Widths
// ----------------------------------------
`define EAWT_CNT_W 5
`define EAWT_BUS_AW 4

`endif

// *** design/eawt_pkg.sv ***
// Types shared by the area wait timing design
package eawt_pkg;

	// Access sequencer states, Gray coded in declaration order
	typedef enum logic [2:0] {
		EAWT_IDLE = 3'h0,
		EAWT_SETUP = 3'h1,
		EAWT_STROBE = 3'h3,
		EAWT_EXTW = 3'h2,
		EAWT_HOLD = 3'h6
	} eawt_state_t;

	// Kind of device attached to the area
	typedef enum logic [1:0] {
		EAWT_AREA_SRAM = 2'h0,
		EAWT_AREA_BYTESEL = 2'h1,
		EAWT_AREA_MPXIO = 2'h2
	} eawt_area_t;

endpackage

// *** design/eawt_timer.sv ***
// Down counter that times each phase of an external access
`timescale 1ns/1ns
`include "eawt_consts.svh"
module eawt_timer (
	input wire logic core_clk,
	input wire logic reset,
	eawt_timer_if.timer tmr
);
	import eawt_pkg::*;

	logic [`EAWT_CNT_W-1:0] count_reg;
	logic [`EAWT_CNT_W-1:0] count_next;

	// ----------------------------------------
	// Next count
	// ----------------------------------------
	always_comb begin
		if (tmr.load) begin
			count_next = tmr.value;
		end else if (count_reg != '0) begin
			count_next = count_reg - `EAWT_CNT_W'(1);
		end else begin
			count_next = count_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign tmr.expired = (count_reg == '0);

endmodule

// *** design/eawt_timer_if.sv ***
// Load and expiry signals between the sequencer and its phase timer
`timescale 1ns/1ns
`include "eawt_consts.svh"
interface eawt_timer_if;
	logic load;
	logic [`EAWT_CNT_W-1:0] value;
	logic expired;
	modport ctrl (output load, output value, input expired);
	modport timer (input load, input value, output expired);
endinterface

// *** design/eawt_top.sv ***
// External area wait and strobe timing controller with Avalon-MM registers
// Behaviour
// [R1] MULTIPLEXED_IO_INTERFACE area: address-wait bit adds one cycle
// [R2] Byte-access bit 0: strobes at read timing
// [R3] Byte-access bit 1: strobes whole cycle
// [R4] Byte-access bit honoured only for byte-select SRAM
// [R5] Bit 19 reads zero; software writes zero
// [R6] Write wait: 000 reuses read wait, else code-1
// [R7] Write wait for writes, read wait for reads
// [R8] Bits 15 to 13 read zero
// [R9] Set-up delay 0.5 to 3.5 cycles
// [R10] Read wait codes map to 0..24 cycles
// [R11] Software never writes read-wait codes 1101 to 1111
// [R12] Mask bit 0 honours external wait, 1 ignores
// [R13] Mask applies even with zero wait cycles
// [R14] Hold delay 0.5 to 3.5 cycles
// [R15] External wait sampled after programmed waits, extends per cycle
`timescale 1ns/1ns
`include "eawt_consts.svh"
module eawt_top #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [`EAWT_BUS_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic [ADDR_W-1:0] acc_addr,
	input wire logic [DATA_W-1:0] acc_wdata,
	input wire logic [1:0] acc_be,
	output logic [DATA_W-1:0] acc_rdata,
	output logic acc_done,
	output logic acc_busy,
	output logic [ADDR_W-1:0] ext_addr,
	output logic chip_select_n,
	output logic read_n,
	output logic [1:0] write_n,
	output logic rd_wr,
	output logic [DATA_W-1:0] ext_data_out,
	output logic ext_data_oe,
	input wire logic [DATA_W-1:0] ext_data_in,
	input wire logic ext_wait_n
);
	import eawt_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [31:0] wait_ctrl_reg;
	logic [31:0] wait_ctrl_next;
	eawt_area_t area_reg;
	eawt_area_t area_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic wreq_reg;
	logic wreq_next;
	logic [2:0] wsync_reg;
	logic wait_level_reg;
	logic wait_level_next;
	eawt_state_t state_reg;
	eawt_state_t state_next;
	logic write_cyc_reg;
	logic write_cyc_next;
	logic [1:0] be_reg;
	logic [1:0] be_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic cs_n_reg;
	logic cs_n_next;
	logic rd_n_reg;
	logic rd_n_next;
	logic [1:0] wr_n_reg;
	logic [1:0] wr_n_next;
	logic rd_wr_reg;
	logic rd_wr_next;
	logic [DATA_W-1:0] dout_reg;
	logic [DATA_W-1:0] dout_next;
	logic oe_reg;
	logic oe_next;
	logic [DATA_W-1:0] acc_rdata_reg;
	logic [DATA_W-1:0] acc_rdata_next;
	logic done_reg;
	logic done_next;
	logic byte_mode;
	logic bas_whole;
	logic mpx_add;
	logic wait_honoured;
	logic [`EAWT_CNT_W-1:0] read_waits;
	logic [`EAWT_CNT_W-1:0] write_waits;
	logic [`EAWT_CNT_W-1:0] setup_cnt;
	logic [`EAWT_CNT_W-1:0] hold_cnt;
	logic [31:0] bus_wmask;

	eawt_timer_if tmr ();

	eawt_timer u_timer (
		.core_clk(core_clk),
		.reset(reset),
		.tmr(tmr.timer)
	);

	// ----------------------------------------
	// Wait code decode
	// ----------------------------------------
	function automatic logic [`EAWT_CNT_W-1:0] read_wait_decode(input logic [3:0] code);
		logic [`EAWT_CNT_W-1:0] n;
		n = 5'h18;
		case (code)
			4'h7: n = 5'h08;
			4'h8: n = 5'h0A;
			4'h9: n = 5'h0C;
			4'hA: n = 5'h0E;
			4'hB: n = 5'h12;
			4'hC: n = 5'h18;
			default: begin
				if (code < 4'h7) begin
					n = {1'b0, code};
				end
			end
		endcase
		return n;
	endfunction

	// [R10] read wait table
	assign read_waits = read_wait_decode(wait_ctrl_reg[`EAWT_WR_MSB:`EAWT_WR_LSB]);
	// [R6] write wait code
	assign write_waits = (wait_ctrl_reg[`EAWT_WW_MSB:`EAWT_WW_LSB] == 3'h0) ? read_waits :
		{2'h0, wait_ctrl_reg[`EAWT_WW_MSB:`EAWT_WW_LSB] - 3'h1};
	// [R1] MULTIPLEXED_IO_INTERFACE address wait
	assign mpx_add = (area_reg == EAWT_AREA_MPXIO) && wait_ctrl_reg[`EAWT_MPX_BIT];
	// [R4] byte-select only
	assign byte_mode = (area_reg == EAWT_AREA_BYTESEL);
	assign bas_whole = byte_mode && wait_ctrl_reg[`EAWT_BAS_BIT];
	// [R9] set-up half cycle rounds up
	assign setup_cnt = {3'h0, wait_ctrl_reg[`EAWT_SW_MSB:`EAWT_SW_LSB]} + {4'h0, mpx_add};
	// [R14] hold half cycle rounds up
	assign hold_cnt = {3'h0, wait_ctrl_reg[`EAWT_HW_MSB:`EAWT_HW_LSB]};
	// [R12] external wait mask
	assign wait_honoured = !wait_ctrl_reg[`EAWT_WM_BIT];

	// ----------------------------------------
	// External wait synchroniser
	// ----------------------------------------
	always_comb begin
		wait_level_next = wait_level_reg;
		if (wsync_reg[1] == wsync_reg[2]) begin
			wait_level_next = !wsync_reg[2];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wsync_reg <= 3'h7;
			wait_level_reg <= 1'b0;
		end else begin
			wsync_reg <= {wsync_reg[1:0], ext_wait_n};
			wait_level_reg <= wait_level_next;
		end
	end

	// ----------------------------------------
	// Register slave
	// ----------------------------------------
	always_comb begin
		bus_wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
			{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wait_ctrl_next = wait_ctrl_reg;
		area_next = area_reg;
		rdata_next = rdata_reg;
		wreq_next = 1'b1;
		if ((avs_read || avs_write) && wreq_reg) begin
			wreq_next = 1'b0;
			case (avs_address)
				`EAWT_OFS_WAIT: begin
					// [R5] reserved bits read zero
					rdata_next = wait_ctrl_reg & `EAWT_WAIT_MASK;
				end
				`EAWT_OFS_CTRL: begin
					rdata_next = {30'h0, area_reg};
				end
				`EAWT_OFS_STAT: begin
					rdata_next = {27'h0, wait_level_reg, state_reg, acc_busy};
				end
				default: begin
					rdata_next = 32'h0000_0000;
				end
			endcase
		end
		if (avs_write && !wreq_reg) begin
			case (avs_address)
				`EAWT_OFS_WAIT: begin
					// [R8] reserved bits never stored
					wait_ctrl_next = ((avs_writedata & bus_wmask) |
						(wait_ctrl_reg & ~bus_wmask)) & `EAWT_WAIT_MASK;
				end
				`EAWT_OFS_CTRL: begin
					if (avs_byteenable[0] && avs_writedata[1:0] != 2'h3) begin
						area_next = eawt_area_t'(avs_writedata[1:0]);
					end
				end
				default: begin
					area_next = area_reg;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wait_ctrl_reg <= `EAWT_WAIT_RST;
			area_reg <= eawt_area_t'(`EAWT_CTRL_RST);
			rdata_reg <= 32'h0000_0000;
			wreq_reg <= 1'b1;
		end else begin
			wait_ctrl_reg <= wait_ctrl_next;
			area_reg <= area_next;
			rdata_reg <= rdata_next;
			wreq_reg <= wreq_next;
		end
	end

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		write_cyc_next = write_cyc_reg;
		be_next = be_reg;
		addr_next = addr_reg;
		cs_n_next = cs_n_reg;
		rd_n_next = rd_n_reg;
		wr_n_next = wr_n_reg;
		rd_wr_next = rd_wr_reg;
		dout_next = dout_reg;
		oe_next = oe_reg;
		acc_rdata_next = acc_rdata_reg;
		done_next = 1'b0;
		tmr.load = 1'b0;
		tmr.value = '0;
		case (state_reg)
			EAWT_IDLE: begin
				if (acc_req) begin
					write_cyc_next = acc_write;
					be_next = acc_be;
					addr_next = acc_addr;
					dout_next = acc_wdata;
					oe_next = acc_write;
					cs_n_next = 1'b0;
					// [R2] direction low for whole write
					rd_wr_next = bas_whole || !acc_write;
					// [R3] byte strobes for whole cycle
					wr_n_next = bas_whole ? ~acc_be : 2'h3;
					// [R9] set-up phase timing
					tmr.load = 1'b1;
					tmr.value = setup_cnt;
					state_next = EAWT_SETUP;
				end
			end
			EAWT_SETUP: begin
				if (tmr.expired) begin
					rd_n_next = write_cyc_reg;
					// [R2] strobes at read timing
					if (write_cyc_reg || byte_mode) begin
						wr_n_next = ~be_reg;
					end
					// [R3] direction at write timing
					if (write_cyc_reg) begin
						rd_wr_next = 1'b0;
					end
					// [R7] per-direction wait count
					tmr.load = 1'b1;
					tmr.value = write_cyc_reg ? write_waits : read_waits;
					state_next = EAWT_STROBE;
				end
			end
			EAWT_STROBE, EAWT_EXTW: begin
				// [R15] sample wait after programmed waits
				if (tmr.expired && !(wait_honoured && wait_level_reg)) begin
					rd_n_next = 1'b1;
					wr_n_next = bas_whole ? wr_n_reg : 2'h3;
					rd_wr_next = bas_whole || !write_cyc_reg;
					acc_rdata_next = write_cyc_reg ? acc_rdata_reg : ext_data_in;
					// [R14] hold phase timing
					tmr.load = 1'b1;
					tmr.value = hold_cnt;
					state_next = EAWT_HOLD;
				end else if (tmr.expired) begin
					// [R13] extend even at zero waits
					state_next = EAWT_EXTW;
				end
			end
			EAWT_HOLD: begin
				if (tmr.expired) begin
					cs_n_next = 1'b1;
					wr_n_next = 2'h3;
					rd_wr_next = 1'b1;
					oe_next = 1'b0;
					done_next = 1'b1;
					state_next = EAWT_IDLE;
				end
			end
			default: begin
				state_next = EAWT_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= EAWT_IDLE;
			write_cyc_reg <= 1'b0;
			be_reg <= 2'h0;
			addr_reg <= '0;
			cs_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 2'h3;
			rd_wr_reg <= 1'b1;
			dout_reg <= '0;
			oe_reg <= 1'b0;
			acc_rdata_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			write_cyc_reg <= write_cyc_next;
			be_reg <= be_next;
			addr_reg <= addr_next;
			cs_n_reg <= cs_n_next;
			rd_n_reg <= rd_n_next;
			wr_n_reg <= wr_n_next;
			rd_wr_reg <= rd_wr_next;
			dout_reg <= dout_next;
			oe_reg <= oe_next;
			acc_rdata_reg <= acc_rdata_next;
			done_reg <= done_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wreq_reg;
	assign acc_rdata = acc_rdata_reg;
	assign acc_done = done_reg;
	assign acc_busy = !cs_n_reg;
	assign ext_addr = addr_reg;
	assign chip_select_n = cs_n_reg;
	assign read_n = rd_n_reg;
	assign write_n = wr_n_reg;
	assign rd_wr = rd_wr_reg;
	assign ext_data_out = dout_reg;
	assign ext_data_oe = oe_reg;

endmodule

// *** dv/eawt_sram_model.sv ***
// Behavioural SRAM with a programmable external wait
`timescale 1ns/1ns
module eawt_sram_model (
	input wire logic core_clk,
	input wire logic [23:0] ext_addr,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic [7:0] stall_cycles,
	output logic [15:0] ext_data_in,
	output logic ext_wait_n
);
	logic [15:0] last_reg = 16'h0000;
	logic [7:0] cnt_reg = 8'h00;
	always @(posedge core_clk) begin
		cnt_reg <= chip_select_n ? 8'h00 : cnt_reg + 8'h01;
		last_reg <= ext_data_in;
	end
	// Data driven only while read, else changing
	assign ext_data_in = (!chip_select_n && !read_n) ? ext_addr[15:0] ^ 16'h5A5A : ~last_reg;
	// Wait held low in the first cycles of a select
	assign ext_wait_n = !(!chip_select_n && cnt_reg < stall_cycles);
endmodule

// *** dv/eawt_top_asserts.sv ***
// Concurrent checks on the area wait timing ports
`timescale 1ns/1ns
module eawt_top_asserts (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic acc_done,
	input wire logic acc_busy,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic [1:0] write_n,
	input wire logic rd_wr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	rsv_bit_zero_a: assert property (!avs_waitrequest |-> !avs_readdata[19])
		else $error("bit 19 read as one");
	rsv_field_zero_a: assert property (!avs_waitrequest |-> avs_readdata[15:13] == 3'h0)
		else $error("bits 15 to 13 read nonzero");
	setup_gap_a: assert property ($fell(chip_select_n) |-> read_n)
		else $error("read strobe with select");
	hold_gap_a: assert property ($rose(read_n) |-> !chip_select_n)
		else $error("select dropped with strobe");
	read_dir_a: assert property (!read_n |-> rd_wr)
		else $error("read strobe in write direction");
	done_end_a: assert property (acc_done |-> $rose(chip_select_n))
		else $error("done without select release");
	done_pulse_a: assert property (acc_done |=> !acc_done)
		else $error("done longer than one cycle");
	done_bound_a: assert property ($fell(chip_select_n) |-> ##[3:200] acc_done)
		else $error("access did not finish");
	busy_select_a: assert property (acc_busy == !chip_select_n)
		else $error("busy differs from select");
endmodule
bind eawt_top eawt_top_asserts eawt_top_asserts_inst (.core_clk, .reset, .avs_readdata,
	.avs_waitrequest, .acc_done, .acc_busy, .chip_select_n, .read_n, .write_n, .rd_wr);

// *** dv/eawt_top_bench.sv ***
// Self-checking bench for the area wait timing block
`timescale 1ns/1ns
module eawt_top_bench;
	import eawt_pkg::*;
	logic core_clk, reset, avs_read, avs_write, avs_waitrequest, acc_req, acc_write, acc_done;
	logic acc_busy, chip_select_n, read_n, rd_wr, ext_data_oe, ext_wait_n;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd_q;
	logic [23:0] acc_addr, ext_addr;
	logic [15:0] acc_rdata, ext_data_out, ext_data_in;
	logic [1:0] acc_be, write_n;
	logic [7:0] stall_cycles;
	int failures = 0, check_count = 0, n_cs, n_rd, n_wr, n_dir, n_pre, n_oe, n_ad;
	eawt_top eawt_top_inst (.core_clk, .reset, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .acc_req,
		.acc_write, .acc_addr, .acc_wdata(16'hC3A5), .acc_be, .acc_rdata, .acc_done, .acc_busy,
		.ext_addr, .chip_select_n, .read_n, .write_n, .rd_wr, .ext_data_out, .ext_data_oe,
		.ext_data_in, .ext_wait_n);
	eawt_sram_model eawt_sram_model_inst (.core_clk, .ext_addr, .chip_select_n, .read_n,
		.stall_cycles, .ext_data_in, .ext_wait_n);
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Phase counters of the current access
	always @(posedge core_clk) begin
		if (!chip_select_n) begin
			n_cs++;
			if (!read_n) n_rd++;
			if (write_n !== 2'h3) n_wr++;
			if (!rd_wr) n_dir++;
			if (ext_data_oe === 1'b1 && ext_data_out === 16'hC3A5) n_oe++;
			if (ext_addr === acc_addr) n_ad++;
			if (read_n && write_n === 2'h3 && n_rd == 0 && n_wr == 0) n_pre++;
		end
	end
	task automatic test_done;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd_q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			failures++;
			test_done;
		end
	endtask
	function automatic logic [31:0] wc(input logic byte_strobe_timing_select, input logic mux_io_address_wait, input logic [2:0] ww,
		input logic [1:0] sw, input logic [3:0] wr, input logic wm, input logic [1:0] hw);
		return {10'h000, byte_strobe_timing_select, mux_io_address_wait, 1'b0, ww, 3'h0, sw, wr, wm, 4'h0, hw};
	endfunction
	function automatic int rdw(input int c);
		int t[6] = '{8, 10, 12, 14, 18, 24};
		return c < 7 ? c : t[c - 7];
	endfunction
	task automatic cfg(input logic [1:0] area, input logic [31:0] w);
		bus(1'b1, 4'h4, {30'h0, area});
		bus(1'b1, 4'h0, w);
	endtask
	task automatic acc(input logic w, input logic [1:0] be);
		int n;
		@(posedge core_clk);
		n_cs = 0;
		n_rd = 0;
		n_wr = 0;
		n_dir = 0;
		n_pre = 0;
		n_oe = 0;
		n_ad = 0;
		acc_write <= w;
		acc_be <= be;
		acc_addr <= acc_addr + 24'h000101;
		acc_req <= 1'b1;
		@(posedge core_clk);
		acc_req <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (acc_done !== 1'b1 && n < 300);
		if (n >= 300) begin
			failures++;
			test_done;
		end
	endtask
	task automatic t_regs;
		bus(1'b0, 4'h0, 32'h0);
		chk("wait reset", 32'h0000_0500, rd_q);
		bus(1'b1, 4'h0, 32'hFFFF_FB7F);
		bus(1'b0, 4'h0, 32'h0);
		chk("wait mask", 32'h0037_1B43, rd_q);
		bus(1'b0, 4'hC, 32'h0);
		chk("unmapped", 32'h0, rd_q);
		$display("regs end");
	endtask
	task automatic t_waits;
		for (int c = 0; c < 13; c++) begin
			cfg(2'h0, wc(1'b0, 1'b0, 3'h0, 2'h0, 4'(c), 1'b1, 2'h0));
			acc(1'b0, 2'h3);
			chk("read strobe", rdw(c) + 1, n_rd);
			chk("read data", {16'h0, acc_addr[15:0] ^ 16'h5A5A}, {16'h0, acc_rdata});
		end
		for (int c = 0; c < 8; c++) begin
			cfg(2'h0, wc(1'b0, 1'b0, 3'(c), 2'h0, 4'h2, 1'b1, 2'h0));
			acc(1'b1, 2'h3);
			chk("write strobe", c == 0 ? 3 : c, n_wr);
			acc(1'b0, 2'h3);
			chk("read beside ww", 3, n_rd);
		end
		$display("waits end");
	endtask
	task automatic t_phases;
		for (int i = 0; i < 4; i++) begin
			cfg(2'h0, wc(1'b0, 1'b0, 3'h0, 2'(i), 4'h0, 1'b1, 2'(i)));
			acc(1'b0, 2'h3);
			chk("setup", i + 1, n_pre);
			chk("select", 2 * i + 3, n_cs);
		end
		for (int a = 0; a < 3; a++) begin
			cfg(2'(a), wc(1'b0, 1'b1, 3'h0, 2'h0, 4'h0, 1'b1, 2'h0));
			acc(1'b0, 2'h3);
			chk("mpx setup", a == 2 ? 2 : 1, n_pre);
		end
		$display("phases end");
	endtask
	task automatic t_bytes;
		cfg(2'h1, wc(1'b0, 1'b0, 3'h0, 2'h0, 4'h0, 1'b1, 2'h0));
		acc(1'b1, 2'h1);
		chk("bs0 strobe", 1, n_wr);
		chk("bs0 dir", n_cs, n_dir);
		chk("write drive", n_cs, n_oe);
		chk("address pins", n_cs, n_ad);
		acc(1'b0, 2'h3);
		chk("bs0 read we", 1, n_wr);
		chk("read no drive", 0, n_oe);
		cfg(2'h1, wc(1'b1, 1'b0, 3'h0, 2'h0, 4'h0, 1'b1, 2'h0));
		acc(1'b0, 2'h3);
		chk("bs1 read we", n_cs, n_wr);
		acc(1'b1, 2'h3);
		chk("bs1 dir", 1, n_dir);
		cfg(2'h0, wc(1'b1, 1'b0, 3'h0, 2'h0, 4'h0, 1'b1, 2'h0));
		acc(1'b1, 2'h3);
		chk("plain strobe", 1, n_wr);
		chk("plain dir", n_cs, n_dir);
		$display("bytes end");
	endtask
	task automatic t_extwait;
		stall_cycles <= 8'd12;
		cfg(2'h0, wc(1'b0, 1'b0, 3'h0, 2'h0, 4'h0, 1'b1, 2'h0));
		acc(1'b0, 2'h3);
		chk("masked", 1, n_rd);
		cfg(2'h2, wc(1'b0, 1'b1, 3'h0, 2'h3, 4'h0, 1'b0, 2'h0));
		acc(1'b0, 2'h3);
		chk("extended", 1, n_rd > 4);
		stall_cycles <= 8'd0;
		acc(1'b0, 2'h3);
		chk("released", 1, n_rd);
		$display("extwait end");
	endtask
	initial begin
		reset = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		acc_req = 1'b0;
		acc_write = 1'b0;
		acc_addr = 24'h0;
		acc_be = 2'h0;
		stall_cycles = 8'h00;
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		t_regs;
		t_waits;
		t_phases;
		t_bytes;
		t_extwait;
		test_done;
	end
endmodule
